// ==== core/ceps_pkg.sv ====
/*
 * Shared constants and carriers of the exception priority unit.
 * Assumes one core clock and an active-low asynchronous reset.
 */
package ceps_pkg;
    // Priority levels and words in one instruction cache line.
    localparam int NPRIO = 18;
    localparam int LINE_WORDS = 8;
    localparam int WIDX_W = 3;
    // Levels that are critical class, and levels that save the next address.
    localparam logic [17:0] CRIT_MASK = 18'h0_403F;
    localparam logic [17:0] NEXT_MASK = 18'h3_8039;
    // Priority level indices, level 1 at index 0.
    localparam logic [4:0] P_DMC = 5'h00;
    localparam logic [4:0] P_IAC = 5'h01;
    localparam logic [4:0] P_IMC = 5'h02;
    localparam logic [4:0] P_DBX = 5'h03;
    localparam logic [4:0] P_CRI = 5'h04;
    localparam logic [4:0] P_WDT = 5'h05;
    localparam logic [4:0] P_ITM = 5'h06;
    localparam logic [4:0] P_ISZ = 5'h07;
    localparam logic [4:0] P_ISP = 5'h08;
    localparam logic [4:0] P_PRG = 5'h09;
    localparam logic [4:0] P_DTM = 5'h0A;
    localparam logic [4:0] P_DSZ = 5'h0B;
    localparam logic [4:0] P_DSW = 5'h0C;
    localparam logic [4:0] P_ALN = 5'h0D;
    localparam logic [4:0] P_DBS = 5'h0E;
    localparam logic [4:0] P_EXT = 5'h0F;
    localparam logic [4:0] P_FIT = 5'h10;
    localparam logic [4:0] P_PIT = 5'h11;
    // Handler offsets per interrupt type.
    localparam logic [15:0] OFS_CRIT = 16'h0100;
    localparam logic [15:0] OFS_MCHK = 16'h0200;
    localparam logic [15:0] OFS_DSI = 16'h0300;
    localparam logic [15:0] OFS_ISI = 16'h0400;
    localparam logic [15:0] OFS_EXT = 16'h0500;
    localparam logic [15:0] OFS_ALN = 16'h0600;
    localparam logic [15:0] OFS_PRG = 16'h0700;
    localparam logic [15:0] OFS_SC = 16'h0C00;
    localparam logic [15:0] OFS_PIT = 16'h1000;
    localparam logic [15:0] OFS_FIT = 16'h1010;
    localparam logic [15:0] OFS_WDT = 16'h1020;
    localparam logic [15:0] OFS_DTLB = 16'h1100;
    localparam logic [15:0] OFS_ITLB = 16'h1200;
    localparam logic [15:0] OFS_DBG = 16'h2000;
    // Zone code that forbids user access, and reset value of words.
    localparam logic [1:0] ZONE_NOACC = 2'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ENTRY = 2'b10} ceps_state_t;

    // Instruction at the execute point.
    typedef struct packed {
        logic vld; logic [31:0] addr; logic [31:0] nxt;
        logic is_sc; logic illegal; logic trap; logic priv;
        logic itlb_miss; logic [1:0] zone; logic exec_ok; logic guarded;
    } ceps_ifetch_t;
    // Data access of that instruction.
    typedef struct packed {
        logic vld; logic write; logic dtlb_miss; logic [1:0] zone;
        logic wr_en; logic user_attr; logic dcbz; logic nocache;
        logic wthru; logic resv; logic [1:0] low;
    } ceps_data_t;
    // Debug events.
    typedef struct packed {
        logic instr_addr_compare_debug; logic exc; logic unconditional_debug_event; logic bt; logic dac;
        logic data_value_compare_debug; logic ic; logic trap_debug_event;
    } ceps_dbg_t;
    // Timer status and enables.
    typedef struct packed {
        logic wdog_st; logic wdog_en; logic fit_st; logic fit_en;
        logic pit_st; logic pit_en;
    } ceps_tmr_t;
    // Machine state enables and modes.
    typedef struct packed {
        logic ce; logic ee; logic de; logic me; logic pr;
        logic ir; logic dr; logic idm;
    } ceps_mode_t;
    // Interrupt entry report.
    typedef struct packed {
        logic take; logic crit; logic [31:0] vec; logic [31:0] ret;
        logic [4:0] cause; logic imc;
    } ceps_irq_t;
endpackage

// ==== core/ceps_prio_enc.sv ====
/*
 * Fixed priority picker: the lowest index request wins.
 * Assumes requests are already gated by their enables.
 */
module ceps_prio_enc
    import ceps_pkg::*;
(
    input wire logic [NPRIO-1:0] req_i,
    output logic [NPRIO-1:0] grant_o,
    output logic [4:0] idx_o,
    output logic any_o
);
    logic [NPRIO:0] seen;
    logic [4:0] idx_or [NPRIO:0];

    assign seen[0] = 1'b0;
    assign idx_or[0] = 5'h00;

    // Each level wins only when no higher level asks.
    genvar g;
    generate
        for (g = 0; g < NPRIO; g++) begin : g_lvl
            assign grant_o[g] = req_i[g] & ~seen[g];
            assign seen[g+1] = seen[g] | req_i[g];
            assign idx_or[g+1] = idx_or[g] | (grant_o[g] ? 5'(g) : 5'h00);
        end
    endgenerate

    assign idx_o = idx_or[NPRIO];
    assign any_o = seen[NPRIO];
endmodule

// ==== core/ceps_fill_track.sv ====
/*
 * Tracks one instruction cache line fill and remembers which words
 * came back with a bus error, so the error is raised only on execution.
 * Assumes the fill words arrive in order after fill_start_i.
 */
module ceps_fill_track
    import ceps_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic fill_start_i,
    input wire logic [26:0] fill_line_i,
    input wire logic fill_wvld_i,
    input wire logic fill_err_i,
    input wire logic [31:0] chk_addr_i,
    output logic line_inval_o,
    output logic err_hit_o
);
    logic [WIDX_W-1:0] cnt_ff;
    logic [LINE_WORDS-1:0] err_ff;
    logic [26:0] line_ff;
    logic bad_ff;
    logic inval_ff;
    logic last_w;
    logic [LINE_WORDS-1:0] nxt_err;

    // Last word of the eight word fill.
    assign last_w = fill_wvld_i & (cnt_ff == WIDX_W'(LINE_WORDS - 1));
    assign nxt_err = fill_start_i ? '0 : (err_ff | ({{(LINE_WORDS-1){1'b0}}, fill_wvld_i & fill_err_i} << cnt_ff));

    // Word counter and error bits of the line being filled.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_ff <= '0;
            err_ff <= '0;
            line_ff <= '0;
            bad_ff <= 1'b0;
            inval_ff <= 1'b0;
        end else begin
            cnt_ff <= fill_start_i ? '0 : cnt_ff + WIDX_W'(fill_wvld_i); // RL6
            err_ff <= nxt_err;
            line_ff <= fill_start_i ? fill_line_i : line_ff;
            bad_ff <= fill_start_i ? 1'b0 : (bad_ff | (last_w & (|nxt_err)));
            inval_ff <= last_w & (|nxt_err); // RL7
        end
    end

    // A bad line is dropped from the cache; the error waits for execution.
    assign line_inval_o = inval_ff;
    assign err_hit_o = bad_ff & (chk_addr_i[31:5] == line_ff) & err_ff[chk_addr_i[4:2]]; // RL7
endmodule

// ==== core/ceps_exception_unit.sv ====
/*
 * Exception recognition and prioritisation for the processor core.
 * Assumes the pipeline presents the instruction at the execute point,
 * its data access, timer status, debug events and interrupt inputs,
 * all synchronous to clk_i, and acknowledges each interrupt entry.
 */
// How it works
// RL1: One interrupt at a time, fixed priority order.
// RL2: Never two interrupts reported at once.
// RL3: Return address: excepting or next instruction.
// RL4: Hold younger instructions while an entry happens.
// RL5: Machine checks are critical; fetch address saved.
// RL6: Cache miss fill brings eight words.
// RL7: Bad fill invalidates line; error waits execution.
// RL8: Instruction machine check suppresses, saves, flags status.
// RL9: Masked exceptions stay as pending status.
// RL10: Unmasking a pending status raises the interrupt.
// RL11: Asynchronous types masked; some synchronous too.
// RL12: Levels one to six are critical.
// RL13: Levels seven to fourteen are noncritical storage faults.
// RL14: Levels fifteen to eighteen: debug, external, timers.
// RL15: Instruction storage: zone, execute bit, guarded.
// RL16: Data storage: zone, write enable, user attribute.
// RL17: Alignment: block zero, misaligned reserve accesses.
// RL18: Program: illegal, trap, privileged in problem state.
// RL19: Debug interrupts only in internal debug mode.
// RL20: Interrupt inputs are levels held by controller.
// RL21: Critical uses second save pair, noncritical first.
// RL22: Handler address is prefix joined with offset.
// RL23: Shared levels are exclusive; either may win.
module ceps_exception_unit
    import ceps_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire ceps_ifetch_t ifc_i,
    input wire ceps_data_t dat_i,
    input wire ceps_dbg_t dbg_i,
    input wire ceps_tmr_t tmr_i,
    input wire ceps_mode_t mode_i,
    input wire logic [31:0] msr_i,
    input wire logic [15:0] vec_prefix_i,
    input wire logic crit_irq_i,
    input wire logic ext_irq_i,
    input wire logic dbus_err_i,
    input wire logic dbg_clr_i,
    input wire logic imc_clr_i,
    input wire logic entry_ack_i,
    input wire logic fill_start_i,
    input wire logic [26:0] fill_line_i,
    input wire logic fill_wvld_i,
    input wire logic fill_err_i,
    output ceps_irq_t irq_o,
    output logic hold_o,
    output logic line_inval_o,
    output logic dmc_pend_o,
    output logic dbg_pend_o,
    output logic imc_stat_o,
    output logic [31:0] save_addr_o,
    output logic [31:0] save_state_o,
    output logic [31:0] crit_save_addr_o,
    output logic [31:0] crit_save_state_o
);
    ceps_state_t state_ff;
    ceps_state_t nxt_state;
    ceps_irq_t irq_ff;
    ceps_irq_t nxt_irq;
    logic dmc_pend_ff;
    logic dbg_pend_ff;
    logic imc_stat_ff;
    logic [31:0] srr0_ff;
    logic [31:0] srr1_ff;
    logic [31:0] crit_save_addr_ff;
    logic [31:0] crit_save_state_ff;
    logic [NPRIO-1:0] req;
    logic [NPRIO-1:0] grant;
    logic [4:0] win_idx;
    logic win_any;
    logic fetch_err;
    logic idle;
    logic take;
    logic dbg_ok;
    logic isi_zone;
    logic isi_prot;
    logic prog_cond;
    logic dsi_zone;
    logic dsi_wr;
    logic aln_cond;
    logic dbg_sync;
    logic win_crit;
    logic use_next;
    logic [15:0] win_ofs;
    logic [31:0] win_ret;

    // Line fill bookkeeping for instruction side bus errors.
    ceps_fill_track u_fill (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .fill_start_i(fill_start_i),
        .fill_line_i(fill_line_i),
        .fill_wvld_i(fill_wvld_i),
        .fill_err_i(fill_err_i),
        .chk_addr_i(ifc_i.addr),
        .line_inval_o(line_inval_o),
        .err_hit_o(fetch_err)
    );

    // Debug events count only in internal debug mode with debug enabled.
    assign dbg_ok = mode_i.idm & mode_i.de; // RL19
    assign dbg_sync = dbg_i.bt | dbg_i.dac | dbg_i.data_value_compare_debug | dbg_i.ic | dbg_i.trap_debug_event;

    // Instruction storage faults under active instruction translation.
    assign isi_zone = mode_i.ir & mode_i.pr & (ifc_i.zone == ZONE_NOACC); // RL15
    assign isi_prot = mode_i.ir & (~ifc_i.exec_ok | ifc_i.guarded); // RL15

    // Program conditions; system call shares the level.
    assign prog_cond = ifc_i.illegal | ifc_i.trap | (ifc_i.priv & mode_i.pr); // RL18

    // Data storage faults under active data translation.
    assign dsi_zone = mode_i.dr & mode_i.pr & (dat_i.zone == ZONE_NOACC); // RL16
    assign dsi_wr = mode_i.dr & dat_i.write & (~dat_i.wr_en | dat_i.user_attr); // RL16

    // Alignment faults.
    assign aln_cond = (dat_i.dcbz & (dat_i.nocache | dat_i.wthru)) | (dat_i.resv & (dat_i.low != 2'h0)); // RL17

    // Request vector in priority order; asynchronous ones gated by their masks.
    assign req[P_DMC] = dmc_pend_ff & mode_i.me; // RL12
    assign req[P_IAC] = ifc_i.vld & dbg_i.instr_addr_compare_debug & dbg_ok; // RL12
    assign req[P_IMC] = ifc_i.vld & fetch_err & mode_i.me; // RL5
    assign req[P_DBX] = dbg_pend_ff & dbg_ok; // RL10
    assign req[P_CRI] = crit_irq_i & mode_i.ce; // RL20
    assign req[P_WDT] = tmr_i.wdog_st & tmr_i.wdog_en & mode_i.ce; // RL11
    assign req[P_ITM] = ifc_i.vld & ifc_i.itlb_miss; // RL13
    assign req[P_ISZ] = ifc_i.vld & isi_zone; // RL13
    assign req[P_ISP] = ifc_i.vld & isi_prot; // RL13
    assign req[P_PRG] = ifc_i.vld & (prog_cond | ifc_i.is_sc); // RL13
    assign req[P_DTM] = dat_i.vld & dat_i.dtlb_miss; // RL13
    assign req[P_DSZ] = dat_i.vld & dsi_zone; // RL13
    assign req[P_DSW] = dat_i.vld & dsi_wr; // RL13
    assign req[P_ALN] = dat_i.vld & aln_cond; // RL13
    assign req[P_DBS] = ifc_i.vld & dbg_sync & dbg_ok; // RL14
    assign req[P_EXT] = ext_irq_i & mode_i.ee; // RL20
    assign req[P_FIT] = tmr_i.fit_st & tmr_i.fit_en & mode_i.ee; // RL14
    assign req[P_PIT] = tmr_i.pit_st & tmr_i.pit_en & mode_i.ee; // RL14

    // Single winner among all pending requests.
    ceps_prio_enc u_prio (
        .req_i(req),
        .grant_o(grant),
        .idx_o(win_idx),
        .any_o(win_any)
    );

    // Class and return address of the winner.
    assign win_crit = CRIT_MASK[win_idx]; // RL5
    assign use_next = NEXT_MASK[win_idx] | ((win_idx == P_PRG) & ~prog_cond); // RL3
    assign win_ret = use_next ? ifc_i.nxt : ifc_i.addr; // RL3

    // Handler offset of the winner; shared levels pick by their own cause.
    always_comb begin
        case (win_idx)
            P_DMC: win_ofs = OFS_MCHK;
            P_IMC: win_ofs = OFS_MCHK;
            P_IAC: win_ofs = OFS_DBG;
            P_DBX: win_ofs = OFS_DBG;
            P_DBS: win_ofs = OFS_DBG;
            P_CRI: win_ofs = OFS_CRIT;
            P_WDT: win_ofs = OFS_WDT;
            P_ITM: win_ofs = OFS_ITLB;
            P_ISZ: win_ofs = OFS_ISI;
            P_ISP: win_ofs = OFS_ISI;
            P_PRG: win_ofs = prog_cond ? OFS_PRG : OFS_SC; // RL23
            P_DTM: win_ofs = OFS_DTLB;
            P_DSZ: win_ofs = OFS_DSI;
            P_DSW: win_ofs = OFS_DSI;
            P_ALN: win_ofs = OFS_ALN;
            P_EXT: win_ofs = OFS_EXT;
            P_FIT: win_ofs = OFS_FIT;
            default: win_ofs = OFS_PIT;
        endcase
    end

    // Entry only from idle, so a single interrupt is in flight.
    assign idle = (state_ff == ST_IDLE);
    assign take = idle & win_any; // RL1

    // Younger instructions and a suppressed fetch error wait for the entry.
    assign hold_o = take | (state_ff == ST_ENTRY); // RL4

    // Next state: stay in entry until the pipeline has redirected.
    always_comb begin
        case (state_ff)
            ST_IDLE: nxt_state = win_any ? ST_ENTRY : ST_IDLE;
            ST_ENTRY: nxt_state = entry_ack_i ? ST_IDLE : ST_ENTRY;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Report for the interrupt being entered; take lasts one cycle.
    always_comb begin
        nxt_irq = irq_ff;
        nxt_irq.take = take; // RL2
        if (take) begin
            nxt_irq.crit = win_crit;
            nxt_irq.vec = {vec_prefix_i, win_ofs}; // RL22
            nxt_irq.ret = win_ret;
            nxt_irq.cause = win_idx;
            nxt_irq.imc = grant[P_IMC]; // RL8
        end
    end

    // Control state and the interrupt report.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= ST_IDLE;
            irq_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            irq_ff <= nxt_irq;
        end
    end

    // Sticky pending status bits; a new event wins over a clear.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dmc_pend_ff <= 1'b0;
            dbg_pend_ff <= 1'b0;
            imc_stat_ff <= 1'b0;
        end else begin
            dmc_pend_ff <= dbus_err_i | (dmc_pend_ff & ~(take & grant[P_DMC])); // RL9
            dbg_pend_ff <= dbg_i.exc | dbg_i.unconditional_debug_event | (dbg_pend_ff & ~dbg_clr_i); // RL9
            imc_stat_ff <= (take & grant[P_IMC]) | (imc_stat_ff & ~imc_clr_i); // RL8
        end
    end

    // Save pairs: critical entries use the second pair.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            srr0_ff <= RST_WORD;
            srr1_ff <= RST_WORD;
            crit_save_addr_ff <= RST_WORD;
            crit_save_state_ff <= RST_WORD;
        end else if (take & win_crit) begin
            crit_save_addr_ff <= win_ret; // RL21
            crit_save_state_ff <= msr_i; // RL21
        end else if (take) begin
            srr0_ff <= win_ret; // RL21
            srr1_ff <= msr_i; // RL21
        end
    end

    // Outputs straight from flip-flops.
    assign irq_o = irq_ff;
    assign dmc_pend_o = dmc_pend_ff;
    assign dbg_pend_o = dbg_pend_ff;
    assign imc_stat_o = imc_stat_ff;
    assign save_addr_o = srr0_ff;
    assign save_state_o = srr1_ff;
    assign crit_save_addr_o = crit_save_addr_ff;
    assign crit_save_state_o = crit_save_state_ff;
endmodule

// ==== tb/ceps_exc_properties.sv ====
/*
 * Port checker of the exception unit: entry reports, save pairs, status bits.
 * Assumes it is bound to ceps_exception_unit and sees only its ports.
 */
module ceps_exc_checker
    import ceps_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire ceps_irq_t irq_o,
    input wire logic hold_o,
    input wire logic [15:0] vec_prefix_i,
    input wire ceps_ifetch_t ifc_i,
    input wire logic dbus_err_i,
    input wire logic dmc_pend_o,
    input wire logic line_inval_o,
    input wire logic [31:0] save_addr_o,
    input wire logic [31:0] crit_save_addr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // Each entry is one pulse that follows a held pipeline.
    a_take_single: assert property (irq_o.take |=> !irq_o.take)
        else $error("entry pulse wider than one cycle");
    a_take_held: assert property (irq_o.take |-> hold_o && $past(hold_o))
        else $error("entry without pipeline hold");
    // Class and return address follow the winning cause; the handler address carries the prefix.
    a_class_crit: assert property (irq_o.take |-> irq_o.crit == CRIT_MASK[irq_o.cause])
        else $error("wrong class for cause");
    a_vec_prefix: assert property (irq_o.take |-> irq_o.vec[31:16] == $past(vec_prefix_i))
        else $error("handler prefix wrong");
    a_ret_next: assert property (irq_o.take && NEXT_MASK[irq_o.cause] |-> irq_o.ret == $past(ifc_i.nxt))
        else $error("return is not next address");
    a_ret_fetch: assert property (irq_o.take && irq_o.cause == P_IMC |-> irq_o.ret == $past(ifc_i.addr))
        else $error("fetch check return wrong");
    a_imc_flag: assert property (irq_o.take && irq_o.cause == P_IMC |-> irq_o.imc)
        else $error("fetch check flag missing");
    // The saved address lands in the pair of the entry's class.
    a_crit_pair: assert property (irq_o.take && irq_o.crit |-> crit_save_addr_o == irq_o.ret)
        else $error("critical pair not written");
    a_nonc_pair: assert property (irq_o.take && !irq_o.crit |-> save_addr_o == irq_o.ret)
        else $error("noncritical pair not written");
    // Status bits and invalidation pulses.
    a_dmc_sets: assert property (dbus_err_i |=> dmc_pend_o)
        else $error("data bus error not kept");
    a_inval_pulse: assert property (line_inval_o |=> !line_inval_o)
        else $error("invalidate wider than one cycle");
    c_crit: cover property (irq_o.take && irq_o.crit);
    c_nonc: cover property (irq_o.take && !irq_o.crit);
    c_inval: cover property (line_inval_o);
endmodule

bind ceps_exception_unit ceps_exc_checker ceps_exc_checker_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .irq_o(irq_o), .hold_o(hold_o), .vec_prefix_i(vec_prefix_i), .ifc_i(ifc_i), .dbus_err_i(dbus_err_i),
    .dmc_pend_o(dmc_pend_o), .line_inval_o(line_inval_o), .save_addr_o(save_addr_o),
    .crit_save_addr_o(crit_save_addr_o));

// ==== tb/ceps_irq_ctrl_model.sv ====
/*
 * Interrupt controller model driving the critical and external inputs.
 * Assumes the bench asks for service and withdraws it off the rising edge.
 */
module ceps_irq_ctrl_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic crit_req_i,
    input wire logic ext_req_i,
    output logic crit_irq_o,
    output logic ext_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] crit_ff = '0;
    logic [1:0] ext_ff = '0;
    // A slow controller raises a cycle later; withdrawal drops the level at once.
    always @(posedge clk_i) begin
        crit_ff <= {crit_ff[0], crit_req_i};
        ext_ff <= {ext_ff[0], ext_req_i};
    end
    assign crit_irq_o = crit_req_i && (slow_i ? crit_ff[1] : crit_ff[0]);
    assign ext_irq_o = ext_req_i && (slow_i ? ext_ff[1] : ext_ff[0]);
endmodule

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench of the exception unit with an interrupt controller model.
 * Assumes the package, design, checker and model are compiled before it.
 */
module tb_top
    import ceps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0;
    logic arst_n = 0;
    ceps_ifetch_t ifc = '0;
    ceps_data_t dat = '0;
    ceps_dbg_t dbg = '0;
    ceps_tmr_t tmr = 6'h15;
    ceps_mode_t mode = 8'h0F;
    ceps_irq_t irq;
    logic [31:0] msr = '0, sa, ss, csa, css;
    logic [31:0] seed = 32'h0000_0061;
    logic [15:0] pfx = '0;
    logic [26:0] fl = '0, ln;
    logic [17:0] m;
    logic crit_req = 0, ext_req = 0, crit_irq, ext_irq, slow = 0, sc = 0;
    logic dbus_err = 0, dbg_clr = 0, imc_clr = 0, ack = 0, fs = 0, fv = 0, fe = 0;
    logic hold, line_inval, dmc_pend, dbg_pend, imc_stat;
    int fails = 0, tests_run = 0, cyc = 0, r, k, i;

    // Clock of 4 ns.
    always #2 clk = ~clk;

    ceps_irq_ctrl_model ceps_irq_ctrl_model_i (.clk_i(clk), .slow_i(slow), .crit_req_i(crit_req),
        .ext_req_i(ext_req), .crit_irq_o(crit_irq), .ext_irq_o(ext_irq));
    ceps_exception_unit ceps_exception_unit_i (.clk_i(clk), .arst_n_i(arst_n), .ifc_i(ifc), .dat_i(dat),
        .dbg_i(dbg), .tmr_i(tmr), .mode_i(mode), .msr_i(msr), .vec_prefix_i(pfx), .crit_irq_i(crit_irq),
        .ext_irq_i(ext_irq), .dbus_err_i(dbus_err), .dbg_clr_i(dbg_clr), .imc_clr_i(imc_clr),
        .entry_ack_i(ack), .fill_start_i(fs), .fill_line_i(fl), .fill_wvld_i(fv), .fill_err_i(fe),
        .irq_o(irq), .hold_o(hold), .line_inval_o(line_inval), .dmc_pend_o(dmc_pend),
        .dbg_pend_o(dbg_pend), .imc_stat_o(imc_stat), .save_addr_o(sa), .save_state_o(ss),
        .crit_save_addr_o(csa), .crit_save_state_o(css));

    // Repeatable xorshift source.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Handler offset expected for a priority index.
    function automatic logic [15:0] ofs(int n, logic s);
        case (n)
            0, 2: return OFS_MCHK;
            1, 3, 14: return OFS_DBG;
            4: return OFS_CRIT;
            5: return OFS_WDT;
            6: return OFS_ITLB;
            7, 8: return OFS_ISI;
            9: return s ? OFS_SC : OFS_PRG;
            10: return OFS_DTLB;
            11, 12: return OFS_DSI;
            13: return OFS_ALN;
            15: return OFS_EXT;
            16: return OFS_FIT;
            default: return OFS_PIT;
        endcase
    endfunction

    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Drives one set of exception sources; on=0 masks all and stalls the pipeline.
    task automatic apply(logic [17:0] s, logic on);
        ifc.vld = on;
        ifc.illegal = s[9] & !sc;
        ifc.is_sc = s[9] & sc;
        ifc.itlb_miss = s[6];
        ifc.zone = s[7] ? ZONE_NOACC : 2'h1;
        ifc.exec_ok = !s[8];
        dat.vld = on;
        dat.dtlb_miss = s[10];
        dat.zone = s[11] ? ZONE_NOACC : 2'h1;
        dat.write = s[12];
        dat.wr_en = !s[12];
        dat.dcbz = s[13];
        dat.nocache = s[13];
        dbg.instr_addr_compare_debug = s[1];
        dbg.exc = s[3];
        dbg.bt = s[14];
        tmr.wdog_st = s[5];
        tmr.fit_st = s[16];
        tmr.pit_st = s[17];
        crit_req = s[4];
        ext_req = s[15];
        {mode.ce, mode.ee, mode.de, mode.me} = {4{on}};
    endtask

    // Waits for one entry and compares its report with the expected one.
    task automatic take_chk(int n);
        int w;
        logic cr;
        logic nx;
        w = 0;
        cr = (n <= 5 || n == 14);
        nx = (n == 0 || n == 3 || n == 4 || n == 5 || n >= 15 || (n == 9 && sc));
        while (irq.take !== 1'b1 && w < 20) begin
            @(posedge clk);
            #1;
            w++;
        end
        chk("cause", 32'(irq.cause), 32'(n));
        chk("crit", 32'(irq.crit), 32'(cr));
        chk("vec", irq.vec, {pfx, ofs(n, sc)});
        chk("ret", irq.ret, nx ? ifc.nxt : ifc.addr);
        chk("save_addr", cr ? csa : sa, nx ? ifc.nxt : ifc.addr);
        chk("save_state", cr ? css : ss, msr);
    endtask

    // Acknowledges the entry and withdraws its source.
    task automatic ack_rel(int n);
        @(negedge clk);
        ack = 1;
        dbg_clr = (n == 3);
        imc_clr = (n == 2);
        apply(m, 1);
        @(negedge clk);
        ack = 0;
        dbg_clr = 0;
        imc_clr = 0;
    endtask

    // One line fill; word e carries a bus error, e above 7 means none.
    task automatic fill(logic [26:0] l, int e);
        @(negedge clk);
        fs = 1;
        fl = l;
        @(negedge clk);
        fs = 0;
        for (int j = 0; j <= LINE_WORDS; j++) begin
            fv = (j < LINE_WORDS);
            fe = (j == e);
            @(posedge clk);
            #1;
            chk("line_inval", 32'(line_inval), 32'(j == LINE_WORDS - 1 && e < LINE_WORDS));
            @(negedge clk);
        end
    endtask

    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end

    // Random source sets, first all but the fetch machine check at once, drained in priority order; then fills.
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1;
        for (r = 0; r < 24; r++) begin
            m = (r == 0) ? 18'h3_FFFB : 18'(rnd()) & 18'h3_FFFB;
            ifc.addr = rnd();
            ifc.nxt = ifc.addr + 32'h0000_0004;
            msr = rnd();
            pfx = 16'(rnd());
            sc = ifc.addr[7];
            slow = r[0];
            @(negedge clk);
            dbus_err = m[0];
            apply(m, 0);
            @(negedge clk);
            dbus_err = 0;
            repeat (4) @(negedge clk);
            chk("masked_hold", 32'(hold), 0);
            chk("dmc_pend", 32'(dmc_pend), 32'(m[0]));
            chk("dbg_pend", 32'(dbg_pend), 32'(m[3]));
            apply(m, 1);
            for (k = 0; k < NPRIO; k++) begin
                if (m[k]) begin
                    take_chk(k);
                    m[k] = 0;
                    ack_rel(k);
                end
            end
            repeat (3) @(negedge clk);
            chk("drained", 32'(hold), 0);
        end
        m = '0;
        apply(m, 0);
        ln = 27'(rnd());
        i = int'(rnd() & 32'h0000_0007);
        fill(ln, i);
        ifc.addr = {ln, 3'(i ^ 1), 2'h0};
        apply(m, 1);
        repeat (4) @(negedge clk);
        chk("clean_word", 32'(hold), 0);
        ifc.addr = {ln, 3'(i), 2'h0};
        take_chk(2);
        chk("imc_flag", 32'(irq.imc), 1);
        chk("imc_stat", 32'(imc_stat), 1);
        ack_rel(2);
        ifc.vld = 0;
        repeat (2) @(negedge clk);
        chk("imc_clear", 32'(imc_stat), 0);
        fill(ln, 9);
        ifc.vld = 1;
        repeat (4) @(negedge clk);
        chk("refilled", 32'(hold), 0);
        test_done();
    end
endmodule
